/* rec_pkg.sv */
// shared constants for the regulator enable control block
package rec_pkg;
    // register map, word offsets as the cpu sees them
    localparam logic [15:0] REG_CONTROL_ADDR = 16'h7004;
    localparam logic [15:0] REG_POWER_MGMT_ADDR = 16'h1930;
    localparam logic [15:0] REG_STATUS_ADDR = 16'h7005;
    // regulator_control fields
    localparam int CTRL_USB_EN_BIT = 0;
    localparam int CTRL_VSEL_BIT = 1;
    // rtc_power_mgmt_register fields
    localparam int PM_BANDGAP_POWER_DOWN_BIT = 0;
    localparam int PM_REGULATOR_POWER_DOWN_BIT = 1;
    localparam int PM_WAKE_EN_BIT = 2;
    localparam int PM_ALARM_EN_BIT = 3;
    // status fields
    localparam int ST_ANA_BIT = 0;
    localparam int ST_CORE_BIT = 1;
    localparam int ST_USB_BIT = 2;
    localparam int ST_DOWN_BIT = 3;
    // reset values and voltage select encodings
    localparam logic VSEL_1V3 = 1'b0;
    localparam logic VSEL_1V05 = 1'b1;
    localparam logic USB_RESET_EN = 1'b0;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    // power state encodings
    typedef enum logic [0:0]
    {
        REC_RUN = 1'b0,
        REC_DOWN = 1'b1
    } rec_state_e;
endpackage

/* rec_pin_sync.sv */
// three-stage synchroniser for a pin level, change taken when stages two and three agree
`timescale 1ns/100ps
module rec_pin_sync
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pin and clean level
    input wire logic pinIn,
    output logic levelOut
);
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } rec_sync_s;

    rec_sync_s st_q;
    rec_sync_s st_d;

    // shift the pin through; stage one is read only by stage two
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pinIn;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.lvl = st_q.s3;
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= {4{RESET_VALUE}};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign levelOut = st_q.lvl;
endmodule

/* rec_edge_detect.sv */
// rising edge detector for an already synchronised level
`timescale 1ns/100ps
module rec_edge_detect
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // level and pulse
    input wire logic levelIn,
    output logic risePulse
);
    typedef struct packed
    {
        logic prev;
        logic pulse;
    } rec_edge_s;

    rec_edge_s st_q;
    rec_edge_s st_d;

    // one-cycle pulse on a low-to-high change
    always_comb
    begin
        st_d.prev = levelIn;
        st_d.pulse = levelIn && !st_q.prev;
    end

    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign risePulse = st_q.pulse;
endmodule

/* rec_regulator_ctrl.sv */
// regulator enable control: register file, power-down latch and regulator enables
//
// Notes on behaviour
// R1: either power-down bit turns all regulators off
// R2: only wake pin, alarm, rtc cycle re-enable
// R3: analog regulator on unless powered down
// R4: core regulator off while disable pin high
// R5: software selects core voltage at run time
// R6: core voltage resets to 1.3 V
// R7: usb regulator follows its software enable
// R8: usb regulator disabled after reset
// R9: disabled core or usb output goes hi-z
// R10: board holds core disable pin static
// R11: select bit 0 is 1.3 V, 1 is 1.05 V
// R12: usb enable bit 0 off, 1 on
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module rec_regulator_ctrl
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    // board pins and wake sources
    input wire logic coreRegulatorDisablePin,
    input wire logic wakeupPin,
    input wire logic rtcAlarm,
    input wire logic rtcSupplyGoodn,
    // regulator controls
    output logic analogRegulatorEnable,
    output logic coreRegulatorEnable,
    output logic coreVoltageSelect,
    output logic usbRegulatorEnable,
    // output pin enables, low while the regulator drives its pin, then the power-down status flag
    output logic coreRegulatorOutputOen,
    output logic usbRegulatorOutputOen,
    output logic regulatorsDown
);
    typedef struct packed
    {
        // power-down latch
        rec_pkg::rec_state_e state;
        // software register bits
        logic usbEnable;
        logic voltageSelect;
        logic bandgapPowerDown;
        logic regulatorPowerDown;
        logic wakeEnable;
        logic alarmEnable;
        // registered outputs
        logic anaEn;
        logic coreEn;
        logic usbEn;
        logic vsel;
        logic coreOen;
        logic usbOen;
        logic down;
        // read answer, one cycle only
        logic [15:0] rdData;
    } rec_ctrl_s;

    rec_ctrl_s st_q;
    rec_ctrl_s st_d;

    // synchronised pin levels and one-cycle wake edges
    logic coreDisableLvl;
    logic wakeLvl;
    logic alarmLvl;
    logic supplyLostLvl;
    logic wakeRise;
    logic alarmRise;

    // pins come from outside the clock domain
    rec_pin_sync #(.RESET_VALUE(1'b0)) uCoreDisSync
    (
        .clk(ref_clk),
        .resetn(resetn),
        .pinIn(coreRegulatorDisablePin),
        .levelOut(coreDisableLvl)
    );

    rec_pin_sync #(.RESET_VALUE(1'b0)) uWakeSync
    (
        .clk(ref_clk),
        .resetn(resetn),
        .pinIn(wakeupPin),
        .levelOut(wakeLvl)
    );

    rec_pin_sync #(.RESET_VALUE(1'b0)) uAlarmSync
    (
        .clk(ref_clk),
        .resetn(resetn),
        .pinIn(rtcAlarm),
        .levelOut(alarmLvl)
    );

    rec_pin_sync #(.RESET_VALUE(1'b0)) uSupplySync
    (
        .clk(ref_clk),
        .resetn(resetn),
        .pinIn(rtcSupplyGoodn),
        .levelOut(supplyLostLvl)
    );

    // wake and alarm count on their assertion edge, not a level left high
    rec_edge_detect uWakeEdge
    (
        .clk(ref_clk),
        .resetn(resetn),
        .levelIn(wakeLvl),
        .risePulse(wakeRise)
    );

    rec_edge_detect uAlarmEdge
    (
        .clk(ref_clk),
        .resetn(resetn),
        .levelIn(alarmLvl),
        .risePulse(alarmRise)
    );

    // next state: register writes, power-down latch, enables, read data
    always_comb
    begin
        logic ctrlWrite;
        logic pmWrite;
        logic pinWake;
        logic alarmWake;
        logic supplyWake;
        logic wakeEvent;
        logic pdRequest;
        logic isDown;
        ctrlWrite = 1'b0;
        pmWrite = 1'b0;
        pinWake = 1'b0;
        alarmWake = 1'b0;
        supplyWake = 1'b0;
        wakeEvent = 1'b0;
        pdRequest = 1'b0;
        isDown = 1'b0;
        st_d = st_q;

        // exact decode; a write to the read-only status word matches neither
        ctrlWrite = regWrite && (regAddr == rec_pkg::REG_CONTROL_ADDR);
        pmWrite = regWrite && (regAddr == rec_pkg::REG_POWER_MGMT_ADDR);

        // register writes
        if (ctrlWrite)
        begin
            st_d.usbEnable = regWrData[rec_pkg::CTRL_USB_EN_BIT]; // see R7 see R12
            st_d.voltageSelect = regWrData[rec_pkg::CTRL_VSEL_BIT]; // see R5 see R11
        end
        if (pmWrite)
        begin
            st_d.bandgapPowerDown = regWrData[rec_pkg::PM_BANDGAP_POWER_DOWN_BIT];
            st_d.regulatorPowerDown = regWrData[rec_pkg::PM_REGULATOR_POWER_DOWN_BIT];
            st_d.wakeEnable = regWrData[rec_pkg::PM_WAKE_EN_BIT];
            st_d.alarmEnable = regWrData[rec_pkg::PM_ALARM_EN_BIT];
        end

        // the wake pin counts only if software enabled it beforehand
        pinWake = wakeRise && st_q.wakeEnable; // see R2
        // so does the alarm, with its own enable
        alarmWake = alarmRise && st_q.alarmEnable; // see R2
        // a lost rtc supply always wakes, whatever the enables hold
        supplyWake = supplyLostLvl; // see R2
        wakeEvent = pinWake || alarmWake || supplyWake;
        // the request sees the bits as this cycle's write leaves them
        pdRequest = st_d.bandgapPowerDown || st_d.regulatorPowerDown; // see R1

        // power-down latch: once down, only a wake event brings it back
        unique case (st_q.state)
            rec_pkg::REC_RUN:
            begin
                // either power-down bit drops all three regulators
                if (pdRequest)
                begin
                    st_d.state = rec_pkg::REC_DOWN; // see R1
                end
            end
            rec_pkg::REC_DOWN:
            begin
                if (wakeEvent)
                begin
                    // clearing the bits stops an instant re-shutdown
                    st_d.state = rec_pkg::REC_RUN; // see R2
                    st_d.bandgapPowerDown = 1'b0;
                    st_d.regulatorPowerDown = 1'b0;
                end
            end
        endcase
        // rtc supply cycle also wins over a power-down written the same cycle
        if (supplyLostLvl)
        begin
            st_d.state = rec_pkg::REC_RUN; // see R2
            st_d.bandgapPowerDown = 1'b0;
            st_d.regulatorPowerDown = 1'b0;
        end

        // enables follow the next state, so they move in the same cycle as the latch
        isDown = (st_d.state == rec_pkg::REC_DOWN);
        st_d.down = isDown;
        st_d.vsel = st_d.voltageSelect; // see R11
        if (isDown)
        begin
            // the shared power-down drops every rail, whatever else is set
            st_d.anaEn = 1'b0; // see R1
            st_d.coreEn = 1'b0; // see R1
            st_d.usbEn = 1'b0; // see R1
        end
        else
        begin
            // nothing but the power-down can turn the analog regulator off
            st_d.anaEn = 1'b1; // see R3
            // the disable pin is trusted to stay put, so no filtering beyond the sync
            st_d.coreEn = !coreDisableLvl; // see R4
            // usb rail is independent of the core pin and voltage select
            st_d.usbEn = st_d.usbEnable; // see R7 see R12
        end
        // a rail that is off releases its output pin
        st_d.coreOen = !st_d.coreEn; // see R9
        st_d.usbOen = !st_d.usbEn; // see R9

        // read data stand one cycle after the strobe only
        st_d.rdData = rec_pkg::READ_ZERO;
        if (regRead)
        begin
            unique case (regAddr)
                rec_pkg::REG_CONTROL_ADDR:
                begin
                    // control bits as last written
                    st_d.rdData[rec_pkg::CTRL_USB_EN_BIT] = st_q.usbEnable;
                    st_d.rdData[rec_pkg::CTRL_VSEL_BIT] = st_q.voltageSelect;
                end
                rec_pkg::REG_POWER_MGMT_ADDR:
                begin
                    // power-management bits, pd bits cleared by a wake
                    st_d.rdData[rec_pkg::PM_BANDGAP_POWER_DOWN_BIT] = st_q.bandgapPowerDown;
                    st_d.rdData[rec_pkg::PM_REGULATOR_POWER_DOWN_BIT] = st_q.regulatorPowerDown;
                    st_d.rdData[rec_pkg::PM_WAKE_EN_BIT] = st_q.wakeEnable;
                    st_d.rdData[rec_pkg::PM_ALARM_EN_BIT] = st_q.alarmEnable;
                end
                rec_pkg::REG_STATUS_ADDR:
                begin
                    // live regulator state, read-only
                    st_d.rdData[rec_pkg::ST_ANA_BIT] = st_q.anaEn;
                    st_d.rdData[rec_pkg::ST_CORE_BIT] = st_q.coreEn;
                    st_d.rdData[rec_pkg::ST_USB_BIT] = st_q.usbEn;
                    st_d.rdData[rec_pkg::ST_DOWN_BIT] = st_q.down;
                end
                default:
                begin
                    st_d.rdData = rec_pkg::READ_ZERO; // unmapped reads as zero
                end
            endcase
        end
    end

    // state register; reset values match a fresh power-up
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // running, with both power-down bits clear
            st_q.state <= rec_pkg::REC_RUN;
            st_q.usbEnable <= rec_pkg::USB_RESET_EN; // see R8
            st_q.voltageSelect <= rec_pkg::VSEL_1V3; // see R6
            st_q.bandgapPowerDown <= 1'b0;
            st_q.regulatorPowerDown <= 1'b0;
            st_q.wakeEnable <= 1'b0;
            st_q.alarmEnable <= 1'b0;
            // analog and core rails up, usb rail off and released
            st_q.anaEn <= 1'b1;
            st_q.coreEn <= 1'b1;
            st_q.usbEn <= 1'b0; // see R8
            st_q.vsel <= rec_pkg::VSEL_1V3; // see R6
            st_q.coreOen <= 1'b0;
            st_q.usbOen <= 1'b1;
            st_q.down <= 1'b0;
            // no read answer pending
            st_q.rdData <= rec_pkg::READ_ZERO;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from flip-flops
    assign analogRegulatorEnable = st_q.anaEn;
    assign coreRegulatorEnable = st_q.coreEn;
    assign coreVoltageSelect = st_q.vsel;
    assign usbRegulatorEnable = st_q.usbEn;
    assign coreRegulatorOutputOen = st_q.coreOen;
    assign usbRegulatorOutputOen = st_q.usbOen;
    assign regulatorsDown = st_q.down;
    // read answer, zero outside its cycle
    assign regRdData = st_q.rdData;
endmodule

/* rec_regulator_ctrl_monitor.sv */
// concurrent checks on the regulator enable control ports
`timescale 1ns/100ps
module rec_regulator_ctrl_check
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdData,
    // pins
    input wire logic coreRegulatorDisablePin,
    input wire logic wakeupPin,
    input wire logic rtcAlarm,
    input wire logic rtcSupplyGoodn,
    // regulator controls
    input wire logic analogRegulatorEnable,
    input wire logic coreRegulatorEnable,
    input wire logic coreVoltageSelect,
    input wire logic usbRegulatorEnable,
    input wire logic coreRegulatorOutputOen,
    input wire logic usbRegulatorOutputOen,
    input wire logic regulatorsDown
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // a pd write needs a clean supply, a lost supply blocks power-down
    a_pd_all_off: assert property (regWrite && regAddr == rec_pkg::REG_POWER_MGMT_ADDR
        && (regWrData[0] || regWrData[1]) && !rtcSupplyGoodn |=> !analogRegulatorEnable
        && !coreRegulatorEnable && !usbRegulatorEnable && regulatorsDown)
        else $error("power-down write left a regulator on");
    a_analog_tracks: assert property (analogRegulatorEnable == !regulatorsDown)
        else $error("analog enable off outside power-down");
    // six quiet cycles flush the pin synchronisers, so nothing may wake
    a_down_holds: assert property ((regulatorsDown && !wakeupPin && !rtcAlarm
        && !rtcSupplyGoodn)[*6] |=> regulatorsDown)
        else $error("left power-down without a wake event");
    a_wake_bound: assert property (regulatorsDown && rtcSupplyGoodn
        |-> ##[0:6] !regulatorsDown)
        else $error("supply cycling did not wake");
    a_usb_follows: assert property (regWrite && regAddr == rec_pkg::REG_CONTROL_ADDR
        && !regulatorsDown |=> usbRegulatorEnable == $past(regWrData[0]))
        else $error("usb enable does not follow its bit");
    a_vsel_follows: assert property (regWrite && regAddr == rec_pkg::REG_CONTROL_ADDR
        |=> coreVoltageSelect == $past(regWrData[1]))
        else $error("voltage select does not follow its bit");
    a_usb_hiz: assert property (usbRegulatorOutputOen == !usbRegulatorEnable)
        else $error("usb output enable disagrees with regulator");
    a_core_hiz: assert property (coreRegulatorOutputOen == !coreRegulatorEnable)
        else $error("core output enable disagrees with regulator");
    a_core_pin_off: assert property (coreRegulatorDisablePin[*6]
        |-> !coreRegulatorEnable)
        else $error("core regulator on with disable pin high");
    a_core_pin_on: assert property (!coreRegulatorDisablePin[*6]
        |-> coreRegulatorEnable == !regulatorsDown)
        else $error("core regulator off with disable pin low");
    a_read_idle: assert property (!$past(regRead) |-> regRdData == 16'h0000)
        else $error("read data outside the answer cycle");
    a_reset_values: assert property ($rose(resetn) |-> !usbRegulatorEnable
        && coreVoltageSelect == rec_pkg::VSEL_1V3)
        else $error("wrong values after reset");
endmodule
bind rec_regulator_ctrl rec_regulator_ctrl_check chk_u (.*);

/* rec_regulator_model.sv */
// board model: static disable strap and the two switchable regulator rails
`timescale 1ns/100ps
module rec_regulator_model
(
    // strap request and reset
    input wire logic strapReq,
    input wire logic resetn,
    // block side
    input wire logic coreRegulatorOutputOen,
    input wire logic usbRegulatorOutputOen,
    output logic coreRegulatorDisablePin,
    // rails on the board
    output wire coreRail,
    output wire usbRail
);
    // the strap only moves while the chip is in reset, never in operation
    always_latch
    begin
        if (!resetn)
        begin
            coreRegulatorDisablePin <= strapReq;
        end
    end
    // a released rail floats, no keeper on the board
    assign coreRail = coreRegulatorOutputOen ? 1'bz : 1'b1;
    assign usbRail = usbRegulatorOutputOen ? 1'bz : 1'b1;
endmodule

/* rec_regulator_ctrl_bench.sv */
// self-checking bench for the regulator enable control
`timescale 1ns/100ps
module rec_regulator_ctrl_bench;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic strap = 1'b0;
    logic wakeupPin = 1'b0;
    logic rtcAlarm = 1'b0;
    logic rtcSupplyGoodn = 1'b0;
    wire [15:0] regRdData;
    wire ana, core, vsel, usb, coreOen, usbOen, down, pin, coreRail, usbRail;
    int mismatches = 0;
    int checks = 0;
    localparam logic [15:0] CTL = rec_pkg::REG_CONTROL_ADDR;
    localparam logic [15:0] PM = rec_pkg::REG_POWER_MGMT_ADDR;
    localparam logic [15:0] ST = rec_pkg::REG_STATUS_ADDR;
    rec_regulator_ctrl dut_u (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .coreRegulatorDisablePin(pin), .wakeupPin(wakeupPin), .rtcAlarm(rtcAlarm),
        .rtcSupplyGoodn(rtcSupplyGoodn), .analogRegulatorEnable(ana),
        .coreRegulatorEnable(core), .coreVoltageSelect(vsel), .usbRegulatorEnable(usb),
        .coreRegulatorOutputOen(coreOen), .usbRegulatorOutputOen(usbOen),
        .regulatorsDown(down));
    rec_regulator_model board_u (.strapReq(strap), .resetn(resetn),
        .coreRegulatorOutputOen(coreOen), .usbRegulatorOutputOen(usbOen),
        .coreRegulatorDisablePin(pin), .coreRail(coreRail), .usbRail(usbRail));
    // free-running 100 MHz clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one-cycle write, outputs checked just after the taking edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask
    // bounded wait for a wake, pins sit behind three sync stages
    task automatic wait_up();
        for (int i = 0; i < 10 && down !== 1'b0; i++) cyc(1);
        chk(down, 1'b0);
        chk(ana, 1'b1);
    endtask
    task automatic rst(input logic s);
        @(posedge ref_clk);
        resetn <= 1'b0;
        strap <= s;
        cyc(5);
        resetn <= 1'b1;
        cyc(1);
    endtask
    task automatic t_reset();
        chk({ana, core, vsel, usb, usbOen, down}, 6'b110010);
        chk(usbRail, 1'bz);
        rdc(CTL, 16'h0000);
        rdc(ST, 16'h0003);
        rdc(16'h0123, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_ctrl();
        wr(CTL, 16'h0001);
        chk({usb, usbOen, usbRail}, 3'b101);
        wr(CTL, 16'hFFFE);
        chk({usb, vsel, core}, 3'b011);
        rdc(CTL, 16'h0002);
        wr(CTL, 16'h0000);
        chk(vsel, 1'b0);
        $display("test control done");
    endtask
    task automatic t_pd();
        for (int b = 0; b < 2; b++)
        begin
            wr(CTL, 16'h0001);
            wr(PM, 16'h0004 | (16'h0001 << b));
            chk({ana, core, usb, down, coreOen, usbOen}, 6'b000111);
            chk(coreRail, 1'bz);
            rdc(PM, 16'h0004 | (16'h0001 << b));
            rdc(ST, 16'h0008);
            // clearing the pd bits alone must not wake; wake enable stays set
            wr(PM, 16'h0004);
            cyc(8);
            chk(down, 1'b1);
            wakeupPin <= 1'b1;
            wait_up();
            rdc(PM, 16'h0004);
            wakeupPin <= 1'b0;
        end
        $display("test power-down done");
    endtask
    task automatic t_alarm();
        wr(PM, 16'h000A);
        wakeupPin <= 1'b1;
        cyc(8);
        chk(down, 1'b1);
        wakeupPin <= 1'b0;
        rtcAlarm <= 1'b1;
        wait_up();
        rtcAlarm <= 1'b0;
        wr(PM, 16'h0001);
        rtcSupplyGoodn <= 1'b1;
        wait_up();
        rtcSupplyGoodn <= 1'b0;
        cyc(6);
        $display("test wake sources done");
    endtask
    task automatic t_pin();
        rst(1'b1);
        cyc(6);
        chk({core, coreOen, ana}, 3'b011);
        chk(coreRail, 1'bz);
        rst(1'b0);
        cyc(6);
        chk({core, coreOen}, 2'b10);
        $display("test disable pin done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang short, the tests need under two microseconds
    initial
    begin
        #20000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        cyc(5);
        resetn <= 1'b1;
        cyc(1);
        t_reset();
        t_ctrl();
        t_pd();
        t_alarm();
        t_pin();
        complete_run();
    end
endmodule
